// ### src/tmr16_core.sv
// What this block does
// - sixteen-bit counter counts up, down or clears; flags top and bottom
// - reading count low byte loads latch with upper byte; high read gives latch
// - count high write fills latch; low write loads all sixteen bits
// - clock source zero stops ticks; cpu access to count still works
// - cpu write to count beats clear and count in same cycle
// - each tick clears, increments or decrements per four-bit mode select
// - overflow flag set where mode defines, can request interrupt
// - matching edge on chosen capture source copies count into capture register
// - capture flag set with copy; requests irq; cleared by ack or one
// - capture low read loads latch with capture high; high read gives latch
// - capture register writable only in modes using it as top
// - select bit swaps capture source pin for comparator output
// - capture pin and comparator share one filter and capture edge logic
// - enabled filter changes output after four equal system-clock samples
// - capture edge logic off only in capture-top modes; filter always runs
// - pin level drives capture, so port writes can trigger it
// - each new capture overwrites capture register unread or not
// - sixteen-bit compare every cycle; match sets compare flag next tick
// - compare flag requests irq when enabled; cleared by ack or one
// - compare channel a serves as top in modes that select it
// - pwm modes buffer compare writes, moved at top; others write direct
// - compare reads skip latch; low write moves both bytes at once
// - pin edge reaches counter four to five system clocks later
// - clear-on-match clears at compare a in mode 4, capture in 12
`timescale 1ns/1ps
`include "tmr16_params.svh"
`default_nettype none

module tmr16_core #(
    parameter int FILTER_LEN = `TMR16_FILTER_LEN
) (
    input  wire logic                    CLK,        // system clock
    input  wire logic                    RST_N,      // sync reset, low
    input  wire tmr16_pkg::tmr16_io_req_t IO_REQ,    // cpu i/o access
    output logic [7:0]                   IO_RDATA,   // read data, next cycle
    input  wire logic [3:0]              TAP_TICK,   // prescaler tap pulses
    input  wire logic                    COUNT_PIN,  // external count pin
    input  wire logic                    CAPTURE_PIN, // capture input pin
    input  wire logic                    COMPARATOR_OUT, // comparator level
    input  wire logic [3:0]              IRQ_ACK,    // interrupt executed
    output logic [3:0]                   IRQ,        // interrupt requests
    output tmr16_pkg::tmr16_wave_t       WAVE,       // match, top, bottom
    output logic [3:0]                   ACTION      // compare_output_action
);

    generate
        if (FILTER_LEN < 2 || FILTER_LEN > 16)
        begin : g_bad_len
            $error("FILTER_LEN out of range");
        end
    endgenerate

    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic        cap_sel;
    logic [3:0]  irq_mask;
    logic [3:0]  flags;
    logic [7:0]  latch;
    logic [15:0] timer_count;
    logic [15:0] capture_reg;
    logic        dir_down;
    logic [15:0] cmp_reg [2];
    logic [15:0] cmp_buf [2];
    logic [1:0]  match;

    // cpu access decode
    wire [`TMR16_ADDR_W-1:0] adr = IO_REQ.addr;
    wire [7:0] wdata = IO_REQ.wdata;
    wire wr = IO_REQ.wr;
    wire rd = IO_REQ.rd;
    wire wr_ctrl_a = wr && adr == `TMR16_ADR_CTRL_A;
    wire wr_ctrl_b = wr && adr == `TMR16_ADR_CTRL_B;
    wire wr_cmpctl = wr && adr == `TMR16_ADR_CMP_CTL;
    wire wr_mask   = wr && adr == `TMR16_ADR_IRQ_MASK;
    wire wr_flags  = wr && adr == `TMR16_ADR_IRQ_FLAG;
    wire wr_cnt_l  = wr && adr == `TMR16_ADR_CNT_L;
    wire wr_cap_l  = wr && adr == `TMR16_ADR_CAP_L;
    wire rd_cnt_l  = rd && adr == `TMR16_ADR_CNT_L;
    wire rd_cap_l  = rd && adr == `TMR16_ADR_CAP_L;
    wire wr_high   = wr && (adr == `TMR16_ADR_CNT_H
                         || adr == `TMR16_ADR_CAP_H
                         || adr == `TMR16_ADR_CMPA_H
                         || adr == `TMR16_ADR_CMPB_H);
    wire [1:0] wr_cmp_l = {wr && adr == `TMR16_ADR_CMPB_L,
                           wr && adr == `TMR16_ADR_CMPA_L};
    wire [15:0] wr_word = {latch, wdata};

    // mode decode
    wire [3:0] wgm = {ctrl_b[`TMR16_CB_WGM_HI], ctrl_a[`TMR16_CA_WGM_LO]};
    wire [2:0] cs = ctrl_b[`TMR16_CB_CS];
    wire filter_on = ctrl_b[`TMR16_CB_FILTER];
    wire edge_rise = ctrl_b[`TMR16_CB_EDGE];
    wire dual_slope = wgm == 4'h1 || wgm == 4'h2 || wgm == 4'h3
                   || wgm == 4'h8 || wgm == 4'h9 || wgm == 4'hA
                   || wgm == 4'hB;
    wire pwm_mode = !(wgm == 4'h0 || wgm == 4'h4 || wgm == 4'hC
                   || wgm == 4'hD);
    wire icr_top = wgm == 4'h8 || wgm == 4'hA || wgm == 4'hC
                || wgm == 4'hE;

    function automatic logic [15:0] top_of(input logic [3:0]  m,
                                           input logic [15:0] cmpa,
                                           input logic [15:0] icr);
        case (m)
            4'h1, 4'h5:               top_of = `TMR16_TOP_8BIT;
            4'h2, 4'h6:               top_of = `TMR16_TOP_9BIT;
            4'h3, 4'h7:               top_of = `TMR16_TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF:   top_of = cmpa;
            4'h8, 4'hA, 4'hC, 4'hE:   top_of = icr;
            default:                  top_of = `TMR16_TOP_MAX;
        endcase
    endfunction

    wire [15:0] top_val = top_of(wgm, cmp_reg[0], capture_reg);
    wire at_top = timer_count == top_val;
    wire at_bottom = timer_count == `TMR16_RST_WORD;

    // three-stage pin synchronisers
    // shared sampling for all pins
    wire [2:0] pin_in = {COMPARATOR_OUT, CAPTURE_PIN, COUNT_PIN};
    logic [2:0] pin_lvl;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            logic s1;
            logic s2;
            logic s3;
            always_ff @(posedge CLK)
            begin
                if (!RST_N)
                begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    pin_lvl[gi] <= 1'b0;
                end
                else
                begin
                    s1 <= pin_in[gi];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3)
                        pin_lvl[gi] <= s3;
                end
            end
        end
    endgenerate

    // external count pin edge detector
    logic count_prev;
    wire ext_rise = pin_lvl[0] && !count_prev;
    wire ext_fall = !pin_lvl[0] && count_prev;

    logic tick;
    always_comb
    begin
        case (cs)
            `TMR16_CS_STOP:     tick = 1'b0;
            `TMR16_CS_SYS:      tick = 1'b1;
            `TMR16_CS_EXT_FALL: tick = ext_fall;
            `TMR16_CS_EXT_RISE: tick = ext_rise;
            default:            tick = TAP_TICK[2'(cs - 3'h2)];
        endcase
    end

    // capture source, filter and edge detector
    // comparator replaces pin
    wire cap_src = cap_sel ? pin_lvl[2] : pin_lvl[1];
    logic [FILTER_LEN-1:0] filt_sh;
    logic filt_out;
    logic cap_prev;
    wire filt_all1 = &filt_sh;
    wire filt_all0 = ~|filt_sh;
    // edge logic off when capture is top
    wire cap_edge = edge_rise ? (filt_out && !cap_prev)
                              : (!filt_out && cap_prev);
    wire cap_evt = cap_edge && !icr_top;

    wire next_filt = !filter_on ? cap_src
                   : filt_all1 ? 1'b1
                   : filt_all0 ? 1'b0
                   : filt_out;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            count_prev <= 1'b0;
            filt_sh <= '0;
            filt_out <= 1'b0;
            cap_prev <= 1'b0;
        end
        else
        begin
            count_prev <= pin_lvl[0];
            filt_sh <= {filt_sh[FILTER_LEN-2:0], cap_src};
            filt_out <= next_filt;
            cap_prev <= filt_out;
        end
    end

    // counter next value
    // mode-driven step
    wire going_down = dual_slope && (at_top || (dir_down && !at_bottom));
    wire [15:0] stepped = going_down ? timer_count - 16'h0001
                                     : timer_count + 16'h0001;
    wire clear_now = !dual_slope && at_top;
    wire [15:0] next_count = wr_cnt_l ? wr_word
                           : !tick ? timer_count
                           : clear_now ? `TMR16_RST_WORD
                           : stepped;
    wire next_dir = !dual_slope ? 1'b0
                  : (tick && at_top) ? 1'b1
                  : (tick && at_bottom) ? 1'b0
                  : dir_down;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            timer_count <= `TMR16_RST_WORD;
            dir_down <= 1'b0;
        end
        else
        begin
            timer_count <= next_count;
            dir_down <= next_dir;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            capture_reg <= `TMR16_RST_WORD;
        else if (cap_evt)
            capture_reg <= timer_count;
        else if (wr_cap_l && icr_top)
            capture_reg <= wr_word;
    end

    // compare channels
    wire buf_load = pwm_mode && tick && at_top;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_cmp
            assign match[gi] = timer_count == cmp_reg[gi];
            always_ff @(posedge CLK)
            begin
                if (!RST_N)
                begin
                    cmp_reg[gi] <= `TMR16_RST_WORD;
                    cmp_buf[gi] <= `TMR16_RST_WORD;
                end
                else
                begin
                    if (wr_cmp_l[gi])
                        cmp_buf[gi] <= wr_word;
                    if (wr_cmp_l[gi] && !pwm_mode)
                        cmp_reg[gi] <= wr_word;
                    else if (buf_load)
                        cmp_reg[gi] <= cmp_buf[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            latch <= `TMR16_RST_BYTE;
        else if (rd_cnt_l)
            latch <= timer_count[15:8];
        else if (rd_cap_l)
            latch <= capture_reg[15:8];
        else if (wr_high)
            latch <= wdata;
    end

    // event flags; set wins over clear
    // overflow point per mode
    wire ovf_set = tick && (dual_slope ? (at_bottom && dir_down) : at_top);
    wire [3:0] flag_set;
    assign flag_set[`TMR16_F_OVF]  = ovf_set;
    assign flag_set[`TMR16_F_CMPA] = tick && match[0];
    assign flag_set[`TMR16_F_CMPB] = tick && match[1];
    assign flag_set[`TMR16_F_CAP]  = cap_evt;
    wire [3:0] flag_clr = IRQ_ACK | (wr_flags ? wdata[3:0] : 4'h0);
    wire [3:0] next_flags = (flags & ~flag_clr) | flag_set;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            ctrl_a <= `TMR16_RST_BYTE;
            ctrl_b <= `TMR16_RST_BYTE;
            cap_sel <= 1'b0;
            irq_mask <= `TMR16_RST_FLAGS;
            flags <= `TMR16_RST_FLAGS;
        end
        else
        begin
            if (wr_ctrl_a)
                ctrl_a <= wdata;
            if (wr_ctrl_b)
                ctrl_b <= wdata;
            if (wr_cmpctl)
                cap_sel <= wdata[`TMR16_CC_CAPSEL];
            if (wr_mask)
                irq_mask <= wdata[3:0];
            flags <= next_flags;
        end
    end

    // read mux; compare reads bypass the latch
    logic [7:0] rd_val;
    always_comb
    begin
        case (adr)
            `TMR16_ADR_CTRL_A:   rd_val = ctrl_a;
            `TMR16_ADR_CTRL_B:   rd_val = ctrl_b;
            `TMR16_ADR_CMP_CTL:  rd_val = {7'h00, cap_sel};
            `TMR16_ADR_IRQ_MASK: rd_val = {4'h0, irq_mask};
            `TMR16_ADR_IRQ_FLAG: rd_val = {4'h0, flags};
            `TMR16_ADR_CNT_L:    rd_val = timer_count[7:0];
            `TMR16_ADR_CNT_H:    rd_val = latch;
            `TMR16_ADR_CAP_L:    rd_val = capture_reg[7:0];
            `TMR16_ADR_CAP_H:    rd_val = latch;
            `TMR16_ADR_CMPA_L:   rd_val = cmp_buf[0][7:0];
            `TMR16_ADR_CMPA_H:   rd_val = cmp_buf[0][15:8];
            `TMR16_ADR_CMPB_L:   rd_val = cmp_buf[1][7:0];
            `TMR16_ADR_CMPB_H:   rd_val = cmp_buf[1][15:8];
            default:             rd_val = 8'h00;
        endcase
    end

    // registered outputs
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            IO_RDATA <= 8'h00;
            IRQ <= 4'h0;
            WAVE <= '0;
            ACTION <= 4'h0;
        end
        else
        begin
            IO_RDATA <= rd ? rd_val : 8'h00;
            IRQ <= flags & irq_mask;
            WAVE.match <= match;
            WAVE.at_top <= at_top;
            WAVE.at_bottom <= at_bottom;
            ACTION <= ctrl_a[`TMR16_CA_ACTION];
        end
    end

endmodule

`default_nettype wire

// ### common/tmr16_params.svh
`ifndef TMR16_PARAMS_SVH
`define TMR16_PARAMS_SVH

// i/o location indices on the 8-bit cpu port
`define TMR16_ADDR_W        4
`define TMR16_ADR_CTRL_A    4'h0
`define TMR16_ADR_CTRL_B    4'h1
`define TMR16_ADR_CMP_CTL   4'h2
`define TMR16_ADR_IRQ_MASK  4'h3
`define TMR16_ADR_IRQ_FLAG  4'h4
`define TMR16_ADR_CNT_L     4'h5
`define TMR16_ADR_CNT_H     4'h6
`define TMR16_ADR_CAP_L     4'h7
`define TMR16_ADR_CAP_H     4'h8
`define TMR16_ADR_CMPA_L    4'h9
`define TMR16_ADR_CMPA_H    4'hA
`define TMR16_ADR_CMPB_L    4'hB
`define TMR16_ADR_CMPB_H    4'hC

// timer_control_a fields
`define TMR16_CA_WGM_LO     1:0
`define TMR16_CA_ACTION     7:4
// timer_control_b fields
`define TMR16_CB_FILTER     7
`define TMR16_CB_EDGE       6
`define TMR16_CB_WGM_HI     4:3
`define TMR16_CB_CS         2:0
// comparator_control_status field
`define TMR16_CC_CAPSEL     0
// flag and mask bit positions
`define TMR16_F_OVF         0
`define TMR16_F_CMPA        1
`define TMR16_F_CMPB        2
`define TMR16_F_CAP         3

// reset values
`define TMR16_RST_BYTE      8'h00
`define TMR16_RST_WORD      16'h0000
`define TMR16_RST_FLAGS     4'h0

// clock source codes
`define TMR16_CS_STOP       3'h0
`define TMR16_CS_SYS        3'h1
`define TMR16_CS_EXT_FALL   3'h6
`define TMR16_CS_EXT_RISE   3'h7

// fixed top values
`define TMR16_TOP_8BIT      16'h00FF
`define TMR16_TOP_9BIT      16'h01FF
`define TMR16_TOP_10BIT     16'h03FF
`define TMR16_TOP_MAX       16'hFFFF

// noise filter sample count
`define TMR16_FILTER_LEN    4

`endif

// ### common/tmr16_pkg.sv
`include "tmr16_params.svh"
`default_nettype none

package tmr16_pkg;

    // one cpu i/o access; wr and rd are one-cycle strobes
    typedef struct packed {
        logic [`TMR16_ADDR_W-1:0] addr;
        logic [7:0]               wdata;
        logic                     wr;
        logic                     rd;
    } tmr16_io_req_t;

    // indications toward the waveform generator
    typedef struct packed {
        logic [1:0] match;
        logic       at_top;
        logic       at_bottom;
    } tmr16_wave_t;

endpackage

`default_nettype wire

// ### tb/tmr16_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module tmr16_cpu_model (
    input  wire logic                clk,     // system clock
    input  wire logic [7:0]          rdata,   // read data
    output tmr16_pkg::tmr16_io_req_t io_req,  // bus request
    output logic [3:0]               irq_ack  // interrupt executed
);
    initial
    begin
        io_req  = '0;
        irq_ack = 4'h0;
    end

    // entered 2 ns after an edge, held to the next edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        io_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        #2;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        io_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        #2;
        d = rdata;
    endtask

    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        wr(a + 4'h1, v[15:8]);
        wr(a, v[7:0]);
    endtask

    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a + 4'h1, v[15:8]);
    endtask

    task automatic idle(input int n);
        io_req = '0;
        repeat (n)
        begin
            @(posedge clk);
            #2;
        end
    endtask

    task automatic ack(input logic [3:0] m);
        irq_ack = m;
        @(posedge clk);
        #2;
        irq_ack = 4'h0;
    endtask
endmodule

`default_nettype wire

// ### tb/tmr16_core_assertions.sv
`timescale 1ns/1ps
`include "tmr16_params.svh"
`default_nettype none

module tmr16_core_assertions (
    input wire logic                     CLK,      // system clock
    input wire logic                     RST_N,    // sync reset, low
    input wire tmr16_pkg::tmr16_io_req_t IO_REQ,   // cpu access
    input wire logic [7:0]               IO_RDATA, // read data
    input wire logic [3:0]               IRQ,      // irq requests
    input wire tmr16_pkg::tmr16_wave_t   WAVE,     // match, top, bottom
    input wire logic [3:0]               ACTION    // output action
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    logic [3:0] mask;
    wire        mask_wr = IO_REQ.wr && IO_REQ.addr == `TMR16_ADR_IRQ_MASK;
    wire        act_wr  = IO_REQ.wr && IO_REQ.addr == `TMR16_ADR_CTRL_A;

    // shadow of the interrupt mask
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            mask <= 4'h0;
        else if (mask_wr)
            mask <= IO_REQ.wdata[3:0];
    end

    sequence s_wr(logic [3:0] a);
        IO_REQ.wr && IO_REQ.addr == a;
    endsequence

    sequence s_rd(logic [3:0] a);
        IO_REQ.rd && IO_REQ.addr == a;
    endsequence

    sequence s_pair(logic [3:0] h, logic [3:0] l);
        s_wr(h) ##1 s_wr(l);
    endsequence

    a_rdata_idle: assert property (!$past(IO_REQ.rd) |-> IO_RDATA == 8'h00)
        else $error("read data not idle");
    // control register then output flop: two cycles from the write
    a_action_copy: assert property (act_wr
        |=> ##1 ACTION == $past(IO_REQ.wdata[7:4], 2))
        else $error("action field not copied");
    a_action_hold: assert property (!$past(act_wr, 2) |-> $stable(ACTION))
        else $error("action changed without write");
    a_irq_masked: assert property ((IRQ & ~$past(mask)) == 4'h0)
        else $error("request raised while masked");
    a_reset_bottom: assert property ($rose(RST_N)
        |=> WAVE.match == 2'b11 && WAVE.at_bottom && !WAVE.at_top)
        else $error("wrong indications after reset");
    a_count_pair: assert property (
        s_pair(`TMR16_ADR_CNT_H, `TMR16_ADR_CNT_L)
        ##1 s_rd(`TMR16_ADR_CNT_L) ##1 s_rd(`TMR16_ADR_CNT_H)
        |=> IO_RDATA == $past(IO_REQ.wdata, 4))
        else $error("count high byte not paired");
    a_cmp_low: assert property (
        s_wr(`TMR16_ADR_CMPA_L) ##1 s_rd(`TMR16_ADR_CMPA_L)
        |=> IO_RDATA == $past(IO_REQ.wdata, 2))
        else $error("compare low byte lost");
    a_cmp_high: assert property (
        s_pair(`TMR16_ADR_CMPB_H, `TMR16_ADR_CMPB_L)
        ##1 s_rd(`TMR16_ADR_CMPB_H)
        |=> IO_RDATA == $past(IO_REQ.wdata, 3))
        else $error("compare high byte lost");
    a_unmapped: assert property (IO_REQ.rd && IO_REQ.addr > 4'hC
        |=> IO_RDATA == 8'h00)
        else $error("unmapped read not zero");
endmodule

bind tmr16_core tmr16_core_assertions u_chk (
    .CLK(CLK),
    .RST_N(RST_N),
    .IO_REQ(IO_REQ),
    .IO_RDATA(IO_RDATA),
    .IRQ(IRQ),
    .WAVE(WAVE),
    .ACTION(ACTION)
);

`default_nettype wire

// ### tb/tmr16_core_tb_top.sv
`timescale 1ns/1ps
`include "tmr16_params.svh"
`default_nettype none

module tmr16_core_tb_top;
    localparam int FLT = 4;
    logic                     clk;
    logic                     rst_n;
    logic [2:0]               pins;
    logic [3:0]               tap;
    tmr16_pkg::tmr16_io_req_t io_req;
    logic [7:0]               rdata;
    logic [7:0]               b;
    logic [3:0]               irq_ack;
    logic [3:0]               irq;
    tmr16_pkg::tmr16_wave_t   wave;
    logic [3:0]               action;
    logic [15:0]              v;
    int                       err_total;
    int                       tests_run;
    int                       seed;
    int                       m_cnt;
    int                       m_cap;

    always #12.5 clk = ~clk;

    tmr16_cpu_model cpu (.clk(clk), .rdata(rdata), .io_req(io_req),
        .irq_ack(irq_ack));
    tmr16_core #(.FILTER_LEN(FLT)) dut (.CLK(clk), .RST_N(rst_n),
        .IO_REQ(io_req), .IO_RDATA(rdata), .TAP_TICK(tap),
        .COUNT_PIN(pins[2]), .CAPTURE_PIN(pins[0]), .COMPARATOR_OUT(pins[1]),
        .IRQ_ACK(irq_ack), .IRQ(irq), .WAVE(wave), .ACTION(action));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one level pulse on a tb input pin, then settle
    task automatic pulse(input int src, input int hi);
        pins[src] = 1'b1;
        cpu.idle(hi);
        pins[src] = 1'b0;
        cpu.idle(12);
    endtask

    // cycles between two bottom indications
    task automatic period(input int exp);
        int c;
        // let the bottom seen before the start pass
        cpu.idle(2);
        for (c = 0; c < 300 && wave.at_bottom !== 1'b1; c++)
            cpu.idle(1);
        for (c = 1; c < 300; c++)
        begin
            cpu.idle(1);
            if (wave.at_bottom === 1'b1)
                break;
        end
        if (c >= 300)
        begin
            err_total++;
            end_sim();
        end
        check(16'(c), 16'(exp));
    endtask

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        pins = 3'b000;
        tap = 4'h0;
        err_total = 0;
        tests_run = 0;
        seed = 97;
        repeat (5) @(posedge clk);
        #2;
        rst_n = 1'b1;
        cpu.idle(3);
        for (int a = 0; a < 16; a++)
        begin
            cpu.rd(4'(a), b);
            check(16'(b), 16'h0000);
        end
        b = $random(seed);
        cpu.wr(`TMR16_ADR_CTRL_A, b & 8'hF0);
        cpu.idle(1);
        check(16'(action), 16'(b[7:4]));
        cpu.wr(`TMR16_ADR_IRQ_MASK, 8'h0B);
        cpu.wr(`TMR16_ADR_CTRL_B, 8'h40);
        repeat (3)
        begin
            m_cnt = $random(seed);
            cpu.wr16(`TMR16_ADR_CNT_L, m_cnt[15:0]);
            cpu.rd16(`TMR16_ADR_CNT_L, v);
            check(v, m_cnt[15:0]);
            cpu.idle(20);
            cpu.rd16(`TMR16_ADR_CNT_L, v);
            check(v, m_cnt[15:0]);
        end
        m_cap = $random(seed);
        cpu.wr16(`TMR16_ADR_CMPA_L, m_cap[15:0]);
        cpu.rd16(`TMR16_ADR_CMPA_L, v);
        check(v, m_cap[15:0]);
        cpu.wr16(`TMR16_ADR_CMPB_L, m_cap[31:16]);
        cpu.rd(`TMR16_ADR_CMPB_H, b);
        check(16'(b), 16'(m_cap[31:24]));
        cpu.wr(`TMR16_ADR_CMPB_H, 8'hAA);
        cpu.rd16(`TMR16_ADR_CNT_L, v);
        cpu.wr(`TMR16_ADR_CMPB_L, 8'h55);
        cpu.rd16(`TMR16_ADR_CMPB_L, v);
        check(v, {m_cnt[15:8], 8'h55});
        for (int i = 0; i < 2; i++)
        begin
            m_cap = $random(seed);
            cpu.wr16(`TMR16_ADR_CNT_L, m_cap[15:0]);
            pulse(0, 4);
        end
        check(16'(irq[3]), 16'h0001);
        cpu.rd16(`TMR16_ADR_CAP_L, v);
        check(v, m_cap[15:0]);
        cpu.ack(4'h8);
        cpu.idle(3);
        check(16'(irq[3]), 16'h0000);
        cpu.wr(`TMR16_ADR_CTRL_B, 8'hC0);
        cpu.wr16(`TMR16_ADR_CNT_L, 16'h0BEE);
        pulse(0, FLT - 1);
        cpu.rd(`TMR16_ADR_IRQ_FLAG, b);
        check(16'(b[3]), 16'h0000);
        pulse(0, FLT + 4);
        cpu.rd16(`TMR16_ADR_CAP_L, v);
        check(v, 16'h0BEE);
        cpu.wr(`TMR16_ADR_CTRL_B, 8'h40);
        cpu.wr(`TMR16_ADR_CMP_CTL, 8'h01);
        cpu.wr(`TMR16_ADR_IRQ_FLAG, 8'h08);
        cpu.wr16(`TMR16_ADR_CNT_L, 16'h0C0D);
        pulse(0, 4);
        cpu.rd16(`TMR16_ADR_CAP_L, v);
        check(v, 16'h0BEE);
        pulse(1, 4);
        cpu.rd16(`TMR16_ADR_CAP_L, v);
        check(v, 16'h0C0D);
        cpu.wr(`TMR16_ADR_CMP_CTL, 8'h00);
        cpu.wr(`TMR16_ADR_CTRL_B, 8'h58);
        cpu.wr16(`TMR16_ADR_CAP_L, 16'h0007);
        cpu.rd16(`TMR16_ADR_CAP_L, v);
        check(v, 16'h0007);
        pulse(0, 4);
        cpu.rd16(`TMR16_ADR_CAP_L, v);
        check(v, 16'h0007);
        cpu.wr16(`TMR16_ADR_CNT_L, 16'h0000);
        cpu.wr(`TMR16_ADR_CTRL_B, 8'h59);
        period(8);
        cpu.wr(`TMR16_ADR_CTRL_B, 8'h40);
        cpu.wr16(`TMR16_ADR_CAP_L, 16'h0456);
        cpu.rd16(`TMR16_ADR_CAP_L, v);
        check(v, 16'h0007);
        cpu.wr16(`TMR16_ADR_CNT_L, 16'h0000);
        cpu.wr16(`TMR16_ADR_CMPA_L, 16'h0005);
        cpu.wr(`TMR16_ADR_CTRL_B, 8'h49);
        period(6);
        check(16'(irq[1]), 16'h0001);
        cpu.wr(`TMR16_ADR_CTRL_B, 8'h48);
        cpu.ack(4'h2);
        cpu.idle(3);
        check(16'(irq[1]), 16'h0000);
        cpu.wr16(`TMR16_ADR_CNT_L, 16'h0040);
        cpu.wr16(`TMR16_ADR_CMPA_L, 16'h0040);
        cpu.wr(`TMR16_ADR_CTRL_A, 8'h03);
        cpu.wr(`TMR16_ADR_CTRL_B, 8'h58);
        cpu.wr16(`TMR16_ADR_CMPA_L, 16'h0041);
        cpu.idle(3);
        check(16'(wave.match[0]), 16'h0001);
        check(16'(wave.at_top), 16'h0001);
        check(16'(wave.match[1]), 16'h0000);
        cpu.wr(`TMR16_ADR_CTRL_A, 8'h00);
        cpu.wr(`TMR16_ADR_CTRL_B, 8'h40);
        cpu.wr16(`TMR16_ADR_CMPA_L, 16'h0041);
        cpu.idle(3);
        check(16'(wave.match[0]), 16'h0000);
        cpu.wr(`TMR16_ADR_IRQ_FLAG, 8'h0F);
        cpu.idle(2);
        check(16'(irq[0]), 16'h0000);
        cpu.wr16(`TMR16_ADR_CNT_L, 16'hFFF8);
        cpu.wr(`TMR16_ADR_CTRL_B, 8'h41);
        cpu.idle(20);
        check(16'(irq[0]), 16'h0001);
        cpu.wr16(`TMR16_ADR_CNT_L, 16'h1200);
        cpu.wr(`TMR16_ADR_CTRL_B, 8'h40);
        cpu.rd16(`TMR16_ADR_CNT_L, v);
        check(v, 16'h1201);
        // prescaler tap then external count pin as tick source
        cpu.wr(`TMR16_ADR_CTRL_B, 8'h42);
        cpu.wr16(`TMR16_ADR_CNT_L, 16'h0000);
        repeat (3)
        begin
            tap = 4'h1;
            cpu.idle(1);
            tap = 4'hE;
            cpu.idle(1);
        end
        tap = 4'h0;
        cpu.wr(`TMR16_ADR_CTRL_B, 8'h47);
        pulse(2, 4);
        pulse(2, 4);
        cpu.wr(`TMR16_ADR_CTRL_B, 8'h40);
        cpu.rd16(`TMR16_ADR_CNT_L, v);
        check(v, 16'h0005);
        end_sim();
    end
endmodule

`default_nettype wire
